// *** verification/cpu_core_model.sv ***
// Behavioural CPU core model driving instruction boundaries.
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic i_clk,        // Bus clock
  input  wire logic i_step,       // Finish one instruction
  input  wire logic i_sw_int_req, // Instruction is a software interrupt
  input  wire logic i_force_sw,   // Block asks for a software interrupt
  output logic      o_instr_done, // Boundary pulse
  output logic      o_sw_exec     // Software interrupt finished
);
  // Idle until the first step
  initial begin
    o_instr_done = 1'b0;
    o_sw_exec = 1'b0;
  end
  always @(posedge i_clk) begin : drive
    logic st;
    logic sw;
    st = i_step;
    sw = i_sw_int_req | i_force_sw;
    #1;
    o_instr_done = st;
    o_sw_exec = st & sw;
  end : drive
endmodule // cpu_core_model

// *** verification/irq_vec_checker_assertions.sv ***
// Concurrent checks on the ports of the interrupt vectoring block.
`timescale 1ns/1ps
module irq_vec_checker (
  input wire logic        i_clk,                 // Bus clock
  input wire logic        i_rst,                 // Async reset
  input wire logic        i_pll_lock,            // Lock level
  input wire logic [1:0]  i_tmr_rollover,        // Timer rollovers
  input wire logic [20:9] i_periph_req,          // Outside requests
  input wire logic        i_instr_done,          // Boundary pulse
  input wire logic        i_swi_exec,            // Software entry
  input wire logic        o_imask,               // Global mask
  input wire logic        o_force_swi,           // Forced software entry
  input wire logic [20:1] o_pending_level_bit,   // Pending levels
  input wire logic        o_entry,               // Entry pulse
  input wire logic [15:0] o_vector_addr,         // Vector address
  input wire logic [4:0]  o_entry_level,         // Entry level
  input wire logic        o_push_pc_minus1,      // Stack kind
  input wire logic        o_pll_change_flag,     // Lock change flag
  input wire logic [1:0]  o_timer_overflow_flag  // Overflow flags
);
  import irq_vec_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  chk_entry_pulse: assert property (o_entry |=> !o_entry)
    else $error("entry pulse longer than one cycle");
  chk_entry_mask: assert property (o_entry |-> o_imask)
    else $error("entry left the mask clear");
  chk_soft_vector: assert property (i_instr_done && i_swi_exec |=> o_entry &&
    o_vector_addr == VEC_SWI && !o_push_pc_minus1) else $error("bad software entry");
  chk_mask_block: assert property (i_instr_done && o_imask && !i_swi_exec &&
    !o_force_swi |=> !o_entry) else $error("entry while masked");
  chk_hw_vector: assert property (o_entry && o_push_pc_minus1 |->
    o_vector_addr == 16'hfffc - {10'h000, o_entry_level, 1'b0}) else $error("bad vector");
  chk_lock_toggle: assert property (!$past(i_rst) && i_pll_lock != $past(i_pll_lock)
    |=> o_pll_change_flag) else $error("lock change not flagged");
  chk_ovf_set: assert property (i_tmr_rollover[0] |=> o_timer_overflow_flag[0])
    else $error("rollover not flagged");
  chk_periph_pend: assert property (o_pending_level_bit[20:9] == i_periph_req)
    else $error("outside pending bits wrong");
endmodule // irq_vec_checker

bind interrupt_priority_vectoring irq_vec_checker u_chk (
  .i_clk, .i_rst, .i_pll_lock, .i_tmr_rollover, .i_periph_req, .i_instr_done, .i_swi_exec,
  .o_imask, .o_force_swi, .o_pending_level_bit, .o_entry, .o_vector_addr, .o_entry_level,
  .o_push_pc_minus1, .o_pll_change_flag, .o_timer_overflow_flag
);

// *** verification/tb.sv ***
// Self-checking bench for the interrupt vectoring block.
`timescale 1ns/1ps
module tb;
  import irq_vec_pkg::*;
  logic        i_clk = 1'b0;  // Bus clock
  logic        i_rst = 1'b1;  // Async reset
  logic        pin_n = 1'b1;  // External pin
  logic        pin_msk = 1'b0; // Pin local mask
  logic        lock = 1'b0;   // Lock level
  logic        pll_en = 1'b0; // Lock change enable
  logic        pll_clr = 1'b0; // Lock flag clear
  logic [1:0]  roll = 2'h0;   // Rollovers
  logic [1:0]  ovf_en = 2'h0; // Overflow enables
  logic [1:0]  ovf_clr = 2'h0; // Overflow clears
  logic [3:0]  ch_ev = 4'h0;  // Channel events
  logic [3:0]  ch_en = 4'h0;  // Channel enables
  logic [3:0]  ch_clr = 4'h0; // Channel clears
  logic [20:9] periph = 12'h000; // Outside requests
  logic        step = 1'b0;   // Step request
  logic        sw_req = 1'b0; // Software interrupt request
  logic        brk = 1'b0;    // Break point hit
  logic        mwr = 1'b0;    // Mask write strobe
  logic        mval = 1'b0;   // Mask write value
  logic        ext_clr = 1'b0; // Pin flag clear
  logic        done, sw_ex, imask, force_sw, entry, push_m1, pin_f, pll_f; // Core model and block outputs
  logic [20:1] pend;          // Pending levels
  logic [15:0] vec;           // Vector address
  logic [4:0]  lvl;           // Entry level
  logic [1:0]  ovf_f;         // Overflow flags
  logic [3:0]  ch_f;          // Channel flags
  int          err_count = 0; // Mismatches
  int          n_checks = 0;  // Comparisons
  // Clock at 25 MHz
  always #20 i_clk = ~i_clk;
  interrupt_priority_vectoring DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_ext_irq_pin_n(pin_n), .i_ext_pin_irq_mask(pin_msk),
    .i_ext_flag_clr(ext_clr), .i_pll_lock(lock), .i_pll_change_irq_enable(pll_en),
    .i_pll_flag_clr(pll_clr), .i_tmr_rollover(roll), .i_timer_overflow_irq_enable(ovf_en),
    .i_tmr_ovf_clr(ovf_clr), .i_tmr_ch_event(ch_ev), .i_timer_channel_irq_enable(ch_en),
    .i_tmr_ch_clr(ch_clr), .i_periph_req(periph), .i_instr_done(done), .i_swi_exec(sw_ex),
    .i_brk_hit(brk), .i_imask_wr(mwr), .i_imask_val(mval), .o_imask(imask),
    .o_force_swi(force_sw), .o_pending_level_bit(pend), .o_entry(entry), .o_vector_addr(vec),
    .o_entry_level(lvl), .o_push_pc_minus1(push_m1), .o_ext_pin_irq_flag(pin_f),
    .o_pll_change_flag(pll_f), .o_timer_overflow_flag(ovf_f), .o_timer_channel_flag(ch_f));
  cpu_core_model u_cpu (.i_clk(i_clk), .i_step(step), .i_sw_int_req(sw_req),
    .i_force_sw(force_sw), .o_instr_done(done), .o_sw_exec(sw_ex));
  // Shared helpers: edge, compare, mask clear, one instruction
  task tick();
    @(posedge i_clk);
    #1;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task unmask();
    mwr = 1'b1;
    tick();
    mwr = 1'b0;
  endtask
  task run_instr();
    step = 1'b1;
    tick();
    step = 1'b0;
    tick();
  endtask
  // Reset state of the outputs
  task t_reset();
    check(16'({imask, pin_f, pll_f, ovf_f, ch_f, force_sw, entry}), 16'h400);
    check(vec, VEC_RESET);
    check(16'({lvl, push_m1}), 16'h0);
    $display("t_reset done");
  endtask
  // Timer levels served in order, then the lowest level
  task t_prio();
    ch_en = 4'hf;
    ovf_en = 2'h3;
    ch_ev = 4'hf;
    roll = 2'h3;
    tick();
    ch_ev = 4'h0;
    roll = 2'h0;
    check(16'(pend[8:3]), 16'h3f);
    check(16'({ovf_f, ch_f}), 16'h3f);
    for (int l = 3; l <= 8; l++) begin
      unmask();
      run_instr();
      check(vec, 16'hfffc - 16'(2 * l));
      check(16'({lvl, push_m1, imask}), 16'({5'(l), 2'h3}));
      case (l)
        3, 4: ch_clr[l-3] = 1'b1;
        5: ovf_clr[0] = 1'b1;
        6, 7: ch_clr[l-4] = 1'b1;
        default: ovf_clr[1] = 1'b1;
      endcase
      tick();
      ch_clr = 4'h0;
      ovf_clr = 2'h0;
    end
    periph[20] = 1'b1;
    unmask();
    run_instr();
    check(vec, VEC_LOWEST);
    periph = 12'h000;
    $display("t_prio done");
  endtask
  // Masked and disabled requests are not served
  task t_mask();
    ch_ev[0] = 1'b1;
    tick();
    ch_ev[0] = 1'b0;
    run_instr();
    check(16'(entry), 16'h0);
    ch_en[0] = 1'b0;
    unmask();
    run_instr();
    check(16'({entry, pend[3]}), 16'h0);
    mval = 1'b1;
    mwr = 1'b1;
    tick();
    mwr = 1'b0;
    mval = 1'b0;
    check(16'(imask), 16'h1);
    ch_clr[0] = 1'b1;
    tick();
    ch_clr[0] = 1'b0;
    unmask();
    $display("t_mask done");
  endtask
  // Software entry beats a pending hardware level
  task t_soft();
    ch_ev[1] = 1'b1;
    tick();
    ch_ev[1] = 1'b0;
    sw_req = 1'b1;
    run_instr();
    sw_req = 1'b0;
    check(16'({lvl, push_m1}), 16'h0);
    check(vec, VEC_SWI);
    unmask();
    run_instr();
    check(16'({lvl, push_m1}), 16'h9);
    $display("t_soft done");
  endtask
  // Break forces a software entry while masked
  task t_brk();
    brk = 1'b1;
    tick();
    brk = 1'b0;
    check(16'(force_sw), 16'h1);
    run_instr();
    check(16'({vec, force_sw}), 16'({VEC_SWI, 1'b0}));
    $display("t_brk done");
  endtask
  // Lock change in both directions
  task t_pll();
    lock = 1'b1;
    tick();
    check(16'({pll_f, pend[2]}), 16'h2);
    pll_en = 1'b1;
    unmask();
    run_instr();
    check(vec, 16'hfff8);
    pll_clr = 1'b1;
    tick();
    pll_clr = 1'b0;
    lock = 1'b0;
    tick();
    check(16'(pll_f), 16'h1);
    $display("t_pll done");
  endtask
  // Low pin latches a level-1 request
  task t_pin();
    pin_msk = 1'b1;
    pin_n = 1'b0;
    repeat (4) tick();
    pin_n = 1'b1;
    check(16'({pin_f, pend[1]}), 16'h2);
    pin_msk = 1'b0;
    pll_en = 1'b0;
    unmask();
    run_instr();
    check(vec, 16'hfffa);
    check(16'(pin_f), 16'h0);
    pin_n = 1'b0;
    repeat (4) tick();
    pin_n = 1'b1;
    check(16'(pin_f), 16'h1);
    ext_clr = 1'b1;
    tick();
    ext_clr = 1'b0;
    check(16'(pin_f), 16'h0);
    $display("t_pin done");
  endtask
  // Counts and verdict, then stop
  task print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_prio();
    t_mask();
    t_soft();
    t_brk();
    t_pll();
    t_pin();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge i_clk);
    err_count++;
    print_verdict();
  end
endmodule // tb

// *** verilog/interrupt_priority_vectoring.sv ***
// Interrupt source arbitration, local flags and vector generation.
//
// What this block does
// - Rank 0..20, vectors from FFFC down to FFD4
// - Global mask blocks all sources except software interrupt
// - Software interrupt non-maskable, top priority, vector FFFC
// - Software interrupt stacks PC, hardware stacks PC-1
// - Break point forces a software interrupt instruction
// - Low external pin latches level-1 request, vector FFFA
// - Lock change, either way, sets PLL change flag
// - PLL request only when enabled, level 2, FFF8
// - First timer overflow flag set on modulo rollover
// - First timer overflow request if enabled, level 5
// - First timer channel flags, enabled, levels 3 and 4
// - Second timer overflow flag, enabled, level 8
// - Second timer channel flags, enabled, levels 6 and 7
// - At instruction end, serve highest pending when unmasked
// - Entry sets global mask, no pre-emption afterwards
`timescale 1ns/1ps

module interrupt_priority_vectoring (
  input  wire logic                             i_clk,             // Bus clock, 25 MHz
  input  wire logic                             i_rst,             // Async reset, active high
  // External interrupt pin
  input  wire logic                             i_ext_irq_pin_n,   // External pin, active low
  input  wire logic                             i_ext_pin_irq_mask,// Local mask, 1 blocks
  input  wire logic                             i_ext_flag_clr,    // Software acknowledge pulse
  // Clock generator lock monitor
  input  wire logic                             i_pll_lock,        // Lock indication level
  input  wire logic                             i_pll_change_irq_enable, // PLL request enable
  input  wire logic                             i_pll_flag_clr,    // Clear PLL change flag
  // Timers: overflow bit 0 is the first timer, 1 the second; channel bits 0..1 the first, 2..3 the second
  input  wire logic [irq_vec_pkg::NUM_TIMERS-1:0] i_tmr_rollover,  // Rollover after match
  input  wire logic [irq_vec_pkg::NUM_TIMERS-1:0] i_timer_overflow_irq_enable, // Ovf enable
  input  wire logic [irq_vec_pkg::NUM_TIMERS-1:0] i_tmr_ovf_clr,   // Clear overflow flag
  input  wire logic [irq_vec_pkg::NUM_TIMERS*irq_vec_pkg::NUM_CH-1:0] i_tmr_ch_event, // Cap/cmp
  input  wire logic [irq_vec_pkg::NUM_TIMERS*irq_vec_pkg::NUM_CH-1:0]
                                                i_timer_channel_irq_enable, // Channel enable
  input  wire logic [irq_vec_pkg::NUM_TIMERS*irq_vec_pkg::NUM_CH-1:0] i_tmr_ch_clr, // Clear
  // Requests of the other peripherals, flag already ANDed with enable
  input  wire logic [irq_vec_pkg::LEVEL_LAST:irq_vec_pkg::LVL_PERIPH_FIRST] i_periph_req, // 9..20
  // CPU core side
  input  wire logic                             i_instr_done,      // Instruction boundary pulse
  input  wire logic                             i_swi_exec,        // Software interrupt executed
  input  wire logic                             i_brk_hit,         // Break point reached pulse
  input  wire logic                             i_imask_wr,        // CPU writes the mask bit
  input  wire logic                             i_imask_val,       // Value written to mask bit
  output logic                                  o_imask,           // Global mask bit
  output logic                                  o_force_swi,       // Make CPU run a SOFTWARE_INTERRUPT_INSTR
  output logic [irq_vec_pkg::LEVEL_LAST:1]      o_pending_level_bit, // Pending per level
  output logic                                  o_entry,           // Entry taken, one cycle
  output logic [15:0]                           o_vector_addr,     // Vector high-byte address
  output logic [irq_vec_pkg::LEVEL_W-1:0]       o_entry_level,     // Level of last entry
  output logic                                  o_push_pc_minus1,  // 1: stack PC-1, 0: PC
  output logic                                  o_ext_pin_irq_flag, // External pin flag
  output logic                                  o_pll_change_flag, // PLL change flag
  output logic [irq_vec_pkg::NUM_TIMERS-1:0]    o_timer_overflow_flag, // Overflow flags
  output logic [irq_vec_pkg::NUM_TIMERS*irq_vec_pkg::NUM_CH-1:0] o_timer_channel_flag // Chan
);
  import irq_vec_pkg::*;

  // Pin synchroniser stages and the accepted pin level
  logic                          pin_sync1_ff;   // First stage, read only by stage two
  logic                          pin_sync2_ff;   // Second stage
  logic                          pin_sync3_ff;   // Third stage
  logic                          pin_level_ff;   // Accepted pin level
  logic                          pin_fall;       // Accepted high to low change

  // Local flags
  logic                          ext_flag_ff;    // External pin flag
  logic                          lock_prev_ff;   // Lock level seen last cycle
  logic                          lock_seen_ff;   // Lock history valid after reset
  logic                          pll_flag_ff;    // PLL change flag
  logic [NUM_TIMERS-1:0]         ovf_flag_ff;    // Timer overflow flags
  logic [NUM_TIMERS*NUM_CH-1:0]  ch_flag_ff;     // Timer channel flags

  // Arbitration
  logic                          imask_ff;       // Global mask bit
  logic                          brk_pend_ff;    // Break waiting for its SOFTWARE_INTERRUPT_INSTR
  logic [LEVEL_LAST:1]           pend;           // Combined pending per level
  logic [LEVEL_W-1:0]            win_level;      // Highest pending level
  logic                          take_hw;        // Hardware entry this cycle
  logic                          take_swi;       // Software entry this cycle
  logic                          entry_ff;       // Entry pulse
  logic [15:0]                   vector_ff;      // Vector address register
  logic [LEVEL_W-1:0]            level_ff;       // Entry level register
  entry_kind_e                   kind_ff;        // Kind of last entry

  // Lowest index set wins, 0 when nothing is pending
  function automatic logic [LEVEL_W-1:0] top_level(input logic [LEVEL_LAST:1] req);
    logic [LEVEL_W-1:0] lvl;
    lvl = LVL_NONE;
    for (int i = LEVEL_LAST; i >= 1; i--) begin
      if (req[i]) begin
        lvl = LEVEL_W'(i);
      end
    end
    return lvl;
  endfunction

  // Vector for a level: two bytes below the software vector per level
  function automatic logic [15:0] level_vector(input logic [LEVEL_W-1:0] lvl);
    return VEC_SWI - {10'h000, lvl, 1'b0};
  endfunction

  // Three-stage synchroniser on the external pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_sync1_ff <= RST_PIN_HIGH;
      pin_sync2_ff <= RST_PIN_HIGH;
      pin_sync3_ff <= RST_PIN_HIGH;
    end else begin
      pin_sync1_ff <= i_ext_irq_pin_n;
      pin_sync2_ff <= pin_sync1_ff;
      pin_sync3_ff <= pin_sync2_ff;
    end
  end

  // Accept a new pin level only when stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_level_ff <= RST_PIN_HIGH;
    end else if (pin_sync2_ff == pin_sync3_ff) begin
      pin_level_ff <= pin_sync3_ff;
    end
  end

  // Accepted falling change of the pin
  assign pin_fall = pin_level_ff & ~pin_sync2_ff & ~pin_sync3_ff;

  // Pin low latches request
  // Set wins over a clear in the same cycle; entry at level 1 acknowledges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_flag_ff <= RST_FLAG;
    end else if (pin_fall) begin
      ext_flag_ff <= 1'b1;
    end else if (i_ext_flag_clr || (take_hw && win_level == LVL_EXT_PIN)) begin
      ext_flag_ff <= 1'b0;
    end
  end

  // Lock history; the first sample after reset only arms the detector
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_prev_ff <= 1'b0;
      lock_seen_ff <= 1'b0;
    end else begin
      lock_prev_ff <= i_pll_lock;
      lock_seen_ff <= 1'b1;
    end
  end

  // Lock change sets flag
  // Both entering and leaving lock count; set wins over clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pll_flag_ff <= RST_FLAG;
    end else if (lock_seen_ff && (i_pll_lock != lock_prev_ff)) begin
      pll_flag_ff <= 1'b1;
    end else if (i_pll_flag_clr) begin
      pll_flag_ff <= 1'b0;
    end
  end

  // Per-timer overflow and channel flags
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
    // Rollover sets overflow flag
    // Rollover pulse marks the wrap to zero after a modulo match
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        ovf_flag_ff[t] <= RST_FLAG;
      end else if (i_tmr_rollover[t]) begin
        ovf_flag_ff[t] <= 1'b1;
      end else if (i_tmr_ovf_clr[t]) begin
        ovf_flag_ff[t] <= 1'b0;
      end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          ch_flag_ff[t*NUM_CH+c] <= RST_FLAG;
        end else if (i_tmr_ch_event[t*NUM_CH+c]) begin
          ch_flag_ff[t*NUM_CH+c] <= 1'b1;
        end else if (i_tmr_ch_clr[t*NUM_CH+c]) begin
          ch_flag_ff[t*NUM_CH+c] <= 1'b0;
        end
      end
    end
  end

  // Combined pending per level
  // Each local flag is qualified before ranking: the pin flag by its local mask, the others by their own enable
  always_comb begin
    pend = '0;
    pend[LVL_EXT_PIN] = ext_flag_ff & ~i_ext_pin_irq_mask;
    pend[LVL_PLL]     = pll_flag_ff & i_pll_change_irq_enable;
    pend[LVL_T1_CH0]  = ch_flag_ff[0] & i_timer_channel_irq_enable[0];
    pend[LVL_T1_CH1]  = ch_flag_ff[1] & i_timer_channel_irq_enable[1];
    pend[LVL_T1_OVF]  = ovf_flag_ff[0] & i_timer_overflow_irq_enable[0];
    pend[LVL_T2_CH0]  = ch_flag_ff[2] & i_timer_channel_irq_enable[2];
    pend[LVL_T2_CH1]  = ch_flag_ff[3] & i_timer_channel_irq_enable[3];
    pend[LVL_T2_OVF]  = ovf_flag_ff[1] & i_timer_overflow_irq_enable[1];
    // Outside peripherals arrive already combined
    pend[LEVEL_LAST:LVL_PERIPH_FIRST] = i_periph_req;
  end

  assign win_level = top_level(pend);

  // Software interrupt ignores mask
  // An executed SOFTWARE_INTERRUPT_INSTR or a forced one from the break logic enters at level 0
  assign take_swi = i_instr_done & (i_swi_exec | brk_pend_ff);

  // Mask blocks hardware sources
  // SOFTWARE_INTERRUPT_INSTR has precedence at the same boundary
  assign take_hw  = i_instr_done & ~take_swi & ~imask_ff & (win_level != LVL_NONE);

  // Break forces software interrupt
  // Held until the SOFTWARE_INTERRUPT_INSTR entry happens; a new hit wins over the clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      brk_pend_ff <= 1'b0;
    end else if (i_brk_hit) begin
      brk_pend_ff <= 1'b1;
    end else if (take_swi) begin
      brk_pend_ff <= 1'b0;
    end
  end

  // Entry sets global mask
  // Entry wins over a CPU write in the same cycle, so nothing pre-empts
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      imask_ff <= RST_IMASK;
    end else if (take_swi || take_hw) begin
      imask_ff <= 1'b1;
    end else if (i_imask_wr) begin
      imask_ff <= i_imask_val;
    end
  end

  // Entry pulse, one cycle after the winning boundary
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      entry_ff <= 1'b0;
    end else begin
      entry_ff <= take_swi | take_hw;
    end
  end

  // Vector per rank
  // Registers hold the last entry until the next one; reset shows level 0
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vector_ff <= VEC_RESET;
      level_ff  <= LVL_NONE;
      kind_ff   <= ENTRY_RESET;
    end else if (take_swi) begin
      vector_ff <= VEC_SWI;
      level_ff  <= LVL_NONE;
      kind_ff   <= ENTRY_SWI;
    end else if (take_hw) begin
      vector_ff <= level_vector(win_level);
      level_ff  <= win_level;
      kind_ff   <= ENTRY_HW;
    end
  end

  always_comb begin
    case (kind_ff)
      ENTRY_HW:    o_push_pc_minus1 = 1'b1;
      ENTRY_SWI:   o_push_pc_minus1 = 1'b0;
      ENTRY_RESET: o_push_pc_minus1 = 1'b0;
      default:     o_push_pc_minus1 = 1'b0;
    endcase
  end

  // Outputs
  assign o_imask               = imask_ff;
  assign o_force_swi           = brk_pend_ff;
  assign o_pending_level_bit   = pend;
  assign o_entry               = entry_ff;
  assign o_vector_addr         = vector_ff;
  assign o_entry_level         = level_ff;
  assign o_ext_pin_irq_flag    = ext_flag_ff;
  assign o_pll_change_flag     = pll_flag_ff;
  assign o_timer_overflow_flag = ovf_flag_ff;
  assign o_timer_channel_flag  = ch_flag_ff;

endmodule // interrupt_priority_vectoring

// *** verilog/irq_vec_pkg.sv ***
// Constants shared by the interrupt priority and vectoring block.
package irq_vec_pkg;

  // Priority scale: 0 is the highest, 20 the lowest
  localparam int unsigned LEVEL_TOP   = 0;
  localparam int unsigned LEVEL_LAST  = 20;
  localparam int unsigned LEVEL_W     = 5;

  // Fixed priority levels of the local sources
  localparam logic [LEVEL_W-1:0] LVL_EXT_PIN   = 5'h01;
  localparam logic [LEVEL_W-1:0] LVL_PLL       = 5'h02;
  localparam logic [LEVEL_W-1:0] LVL_T1_CH0    = 5'h03;
  localparam logic [LEVEL_W-1:0] LVL_T1_CH1    = 5'h04;
  localparam logic [LEVEL_W-1:0] LVL_T1_OVF    = 5'h05;
  localparam logic [LEVEL_W-1:0] LVL_T2_CH0    = 5'h06;
  localparam logic [LEVEL_W-1:0] LVL_T2_CH1    = 5'h07;
  localparam logic [LEVEL_W-1:0] LVL_T2_OVF    = 5'h08;
  localparam logic [LEVEL_W-1:0] LVL_NONE      = 5'h00;

  // First level fed straight from outside peripherals
  localparam int unsigned LVL_PERIPH_FIRST = 9;

  // Vector addresses (high byte address of each two-byte vector)
  localparam logic [15:0] VEC_RESET    = 16'hfffe;
  localparam logic [15:0] VEC_SWI      = 16'hfffc;
  localparam logic [15:0] VEC_LOWEST   = 16'hffd4;

  // Number of timers and channels per timer
  localparam int unsigned NUM_TIMERS   = 2;
  localparam int unsigned NUM_CH       = 2;

  // Reset values
  localparam logic        RST_IMASK    = 1'b1;
  localparam logic        RST_FLAG     = 1'b0;
  localparam logic        RST_PIN_HIGH = 1'b1;

  // Kind of entry that was taken
  typedef enum logic [1:0] {
    ENTRY_RESET,
    ENTRY_SWI,
    ENTRY_HW
  } entry_kind_e;

endpackage
